// >>> rtl/task_file_pkg.sv
// shared constants and carrier types for the task-file host port
package task_file_pkg;

  // register select codes on the three address lines
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_FAULT = 3'h1;
  localparam logic [2:0] ADDR_COUNT = 3'h2;
  localparam logic [2:0] ADDR_SECTOR = 3'h3;
  localparam logic [2:0] ADDR_TRACK_LO = 3'h4;
  localparam logic [2:0] ADDR_TRACK_HI = 3'h5;
  localparam logic [2:0] ADDR_UNIT_HEAD = 3'h6;
  localparam logic [2:0] ADDR_STATUS = 3'h7;
  localparam logic [2:0] ADDR_ALT_STATUS = 3'h6;
  localparam logic [2:0] ADDR_UNIT_ADDR = 3'h7;

  // fault flag positions
  localparam int BIT_BAD_BLOCK = 7;
  localparam int BIT_UNCORRECTABLE = 6;
  localparam int BIT_SECTOR_ID_MISSING = 4;
  localparam int BIT_COMMAND_ABORTED = 2;
  localparam int BIT_HOME_TRACK_MISSING = 1;
  localparam logic [7:0] FAULT_USED_MASK = 8'hD6;

  // unit/head and track high register layout
  localparam int BIT_UNIT_SELECT = 4;
  localparam logic [7:0] UNIT_HEAD_FIXED_ONES = 8'h20;
  localparam logic [7:0] UNIT_HEAD_WRITE_MASK = 8'h9F;
  localparam logic [7:0] TRACK_HI_MASK = 8'h03;

  // digital output register bits
  localparam int BIT_IRQ_GATE = 1;

  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] RESET_UNIT_HEAD = 8'h20;
  localparam logic [7:0] RESET_COUNT = 8'h01;
  localparam logic [7:0] RESET_SECTOR = 8'h01;

  // per-sector update from the drive controller
  typedef struct packed {
    logic ok;
    logic [7:0] next_sector;
    logic [9:0] track;
    logic [3:0] head;
  } sector_update_t;

  // chip select decode results
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_LOW = 2'b01,
    SEL_HIGH = 2'b10,
    SEL_BAD = 2'b11
  } select_t;

endpackage : task_file_pkg

// >>> rtl/disk_task_file_host_port.sv
// task-file register port of the drive, facing the host bus adapter
// Notes on behaviour
// - write data is captured into the addressed register at write strobe rising edge
// - selected register drives the data lines while read strobe is low
// - registers and ECC bytes use the low byte; data words use all sixteen
// - interrupt line driven only when this drive selected and gate bit set
// - interrupt flag set by controller, cleared by status read or command write
// - wide indication asserted when data register addressed and word transfer ready, outside the ECC phase
// - slave drives passed line after self-test; master reads it as input
// - strap picks activity (busy low) or slave-present (open-drain low)
// - address latch qualifier ignored by decode
// - high select: 110 alt status / digital out, 111 unit address, others float
// - low select: 000..111 data, fault, count, sector, tracks, unit/head, status/cmd
// - upper byte enabled only for data words with wide enable, never ECC
// - unused write bits ignored, unused read bits return zero
// - sector data words are 16-bit; ECC bytes follow as 8-bit transfers
// - fault flags at 7,6,4,2,1; bits 5,3,0 read zero
// - after power-up or diagnostics the fault register holds a diagnostic code; here reset loads 00 and controller loads keep only flag bits 7,6,4,2,1
// - aborted flag set on drive status problem or invalid command code
// - precomp register only enables look-ahead reads
// - count zero means 256; decremented per completed sector
// - sector number advances on success, stays at failing sector otherwise
// - track low 8 bits and high 2 bits updated per sector and at end
// - unit/head: bit7 host, bit6 0, bit5 1, bit4 unit, head 3:0
`timescale 1ns/1ps
`default_nettype none

module disk_task_file_host_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // host address and strobes
  input wire logic low_chip_select_n,
  input wire logic high_chip_select_n,
  input wire logic [2:0] register_select_lines,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic address_latch_enable,
  // host data bus, split into in/out/enables
  input wire logic [15:0] host_data_in,
  output logic [15:0] host_data_out,
  output logic host_data_low_oe,
  output logic host_data_high_oe,
  // host side indications
  output logic host_interrupt_line,
  output logic host_interrupt_oe,
  output logic wide_transfer_indicator_n,
  output logic wide_transfer_oe,
  input wire logic passed_selftest_line_in_n,
  output logic passed_selftest_line_out_n,
  output logic passed_selftest_oe,
  output logic slave_or_activity_line_n,
  output logic slave_or_activity_oe,
  // straps
  input wire logic strap_slave,
  input wire logic strap_activity_mode,
  input wire logic strap_slave_present,
  // drive controller side
  input wire logic ctrl_irq_req,
  input wire logic [7:0] ctrl_status,
  input wire logic ctrl_busy,
  input wire logic ctrl_word_ready,
  input wire logic ctrl_ecc_phase,
  input wire logic ctrl_sector_done,
  input wire task_file_pkg::sector_update_t ctrl_sector_info,
  input wire logic ctrl_fault_load,
  input wire logic [7:0] ctrl_fault_value,
  input wire logic ctrl_selftest_passed,
  input wire logic [7:0] ctrl_unit_address,
  input wire logic [15:0] ctrl_read_word,
  output logic [15:0] ctrl_write_word,
  output logic ctrl_write_word_valid,
  output logic ctrl_read_word_taken,
  output logic [7:0] ctrl_command,
  output logic ctrl_command_valid,
  output logic lookahead_enable,
  output logic soft_reset,
  output logic slave_seen
);

  // decoded select
  task_file_pkg::select_t sel;
  logic wr_q, rd_q, wr_rise, rd_fall, rd_rise;
  logic unit_matches;

  // registers
  logic [7:0] fault_reg, fault_next;
  logic [7:0] lookahead_reg, lookahead_next;
  logic [7:0] count_reg, count_next;
  logic [7:0] sector_reg, sector_next;
  logic [7:0] track_lo_reg, track_lo_next;
  logic [7:0] track_hi_reg, track_hi_next;
  logic [7:0] unit_head_reg, unit_head_next;
  logic [7:0] dig_out_reg, dig_out_next;
  logic irq_reg, irq_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [7:0] cmd_reg, cmd_next;
  logic cmd_valid_reg, cmd_valid_next;
  logic [15:0] wword_reg, wword_next;
  logic wword_valid_reg, wword_valid_next;

  // decode both selects; address latch enable deliberately unused
  function automatic task_file_pkg::select_t decode_sel(input logic lo_n, input logic hi_n);
    case ({lo_n, hi_n})
      2'b01: decode_sel = task_file_pkg::SEL_LOW;
      2'b10: decode_sel = task_file_pkg::SEL_HIGH;
      2'b00: decode_sel = task_file_pkg::SEL_BAD;
      default: decode_sel = task_file_pkg::SEL_NONE;
    endcase
  endfunction : decode_sel

  assign sel = decode_sel(low_chip_select_n, high_chip_select_n);
  // history against present level; history resets high so reset gives no false edge
  assign wr_rise = !wr_q && write_strobe_n;
  assign rd_fall = rd_q && !read_strobe_n;
  assign rd_rise = !rd_q && read_strobe_n;
  assign unit_matches = unit_head_reg[task_file_pkg::BIT_UNIT_SELECT] == strap_slave;

  // strobe history for edge detection
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_q <= 1'b1;
      rd_q <= 1'b1;
    end
    else
    begin
      wr_q <= write_strobe_n;
      rd_q <= read_strobe_n;
    end
  end

  // register next-state: host writes first, controller updates win on collision
  always_comb
  begin
    fault_next = fault_reg;
    lookahead_next = lookahead_reg;
    count_next = count_reg;
    sector_next = sector_reg;
    track_lo_next = track_lo_reg;
    track_hi_next = track_hi_reg;
    unit_head_next = unit_head_reg;
    dig_out_next = dig_out_reg;
    irq_next = irq_reg;
    cmd_next = cmd_reg;
    cmd_valid_next = 1'b0;
    wword_next = wword_reg;
    wword_valid_next = 1'b0;
    if (wr_rise && sel == task_file_pkg::SEL_LOW)
    begin
      case (register_select_lines)
        task_file_pkg::ADDR_DATA:
        begin
          wword_valid_next = 1'b1;
          // ECC bytes carry only the low lane
          wword_next = ctrl_ecc_phase ? {8'h00, host_data_in[7:0]} : host_data_in;
        end
        task_file_pkg::ADDR_FAULT: lookahead_next = host_data_in[7:0];
        task_file_pkg::ADDR_COUNT: count_next = host_data_in[7:0];
        task_file_pkg::ADDR_SECTOR: sector_next = host_data_in[7:0];
        task_file_pkg::ADDR_TRACK_LO: track_lo_next = host_data_in[7:0];
        task_file_pkg::ADDR_TRACK_HI: track_hi_next = host_data_in[7:0] & task_file_pkg::TRACK_HI_MASK;
        task_file_pkg::ADDR_UNIT_HEAD:
          unit_head_next = (host_data_in[7:0] & task_file_pkg::UNIT_HEAD_WRITE_MASK)
            | task_file_pkg::UNIT_HEAD_FIXED_ONES;
        task_file_pkg::ADDR_STATUS:
        begin
          cmd_next = host_data_in[7:0];
          cmd_valid_next = 1'b1;
          irq_next = 1'b0;
        end
        default: cmd_valid_next = 1'b0;
      endcase
    end
    if (wr_rise && sel == task_file_pkg::SEL_HIGH
        && register_select_lines == task_file_pkg::ADDR_ALT_STATUS)
      dig_out_next = host_data_in[7:0];
    // status read acknowledges the interrupt
    if (rd_fall && sel == task_file_pkg::SEL_LOW
        && register_select_lines == task_file_pkg::ADDR_STATUS)
      irq_next = 1'b0;
    // set wins over clear
    if (ctrl_irq_req)
      irq_next = 1'b1;
    if (ctrl_fault_load)
      fault_next = ctrl_fault_value & task_file_pkg::FAULT_USED_MASK;
    if (ctrl_sector_done)
    begin
      if (ctrl_sector_info.ok)
      begin
        count_next = 8'(count_reg - 8'h01); // 0 wraps to 255 of 256
        sector_next = ctrl_sector_info.next_sector;
      end
      track_lo_next = ctrl_sector_info.track[7:0];
      track_hi_next = {6'h00, ctrl_sector_info.track[9:8]};
      unit_head_next = {unit_head_reg[7:4], ctrl_sector_info.head};
    end
  end

  // register storage
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fault_reg <= task_file_pkg::RESET_BYTE;
      lookahead_reg <= task_file_pkg::RESET_BYTE;
      count_reg <= task_file_pkg::RESET_COUNT;
      sector_reg <= task_file_pkg::RESET_SECTOR;
      track_lo_reg <= task_file_pkg::RESET_BYTE;
      track_hi_reg <= task_file_pkg::RESET_BYTE;
      unit_head_reg <= task_file_pkg::RESET_UNIT_HEAD;
      dig_out_reg <= task_file_pkg::RESET_BYTE;
      irq_reg <= 1'b0;
      cmd_reg <= task_file_pkg::RESET_BYTE;
      cmd_valid_reg <= 1'b0;
      wword_reg <= 16'h0000;
      wword_valid_reg <= 1'b0;
    end
    else
    begin
      fault_reg <= fault_next;
      lookahead_reg <= lookahead_next;
      count_reg <= count_next;
      sector_reg <= sector_next;
      track_lo_reg <= track_lo_next;
      track_hi_reg <= track_hi_next;
      unit_head_reg <= unit_head_next;
      dig_out_reg <= dig_out_next;
      irq_reg <= irq_next;
      cmd_reg <= cmd_next;
      cmd_valid_reg <= cmd_valid_next;
      wword_reg <= wword_next;
      wword_valid_reg <= wword_valid_next;
    end
  end

  // read data mux, latched at the start of the read strobe
  always_comb
  begin
    rdata_next = rdata_reg;
    if (rd_fall)
    begin
      rdata_next = 16'h0000;
      if (sel == task_file_pkg::SEL_LOW)
      begin
        case (register_select_lines)
          task_file_pkg::ADDR_DATA:
            rdata_next = ctrl_ecc_phase ? {8'h00, ctrl_read_word[7:0]} : ctrl_read_word;
          task_file_pkg::ADDR_FAULT: rdata_next = {8'h00, fault_reg};
          task_file_pkg::ADDR_COUNT: rdata_next = {8'h00, count_reg};
          task_file_pkg::ADDR_SECTOR: rdata_next = {8'h00, sector_reg};
          task_file_pkg::ADDR_TRACK_LO: rdata_next = {8'h00, track_lo_reg};
          task_file_pkg::ADDR_TRACK_HI: rdata_next = {8'h00, track_hi_reg};
          task_file_pkg::ADDR_UNIT_HEAD: rdata_next = {8'h00, unit_head_reg};
          default: rdata_next = {8'h00, ctrl_status};
        endcase
        // busy locks out the task file except the data register: status is returned instead
        if (ctrl_busy && register_select_lines != task_file_pkg::ADDR_DATA)
          rdata_next = {8'h00, ctrl_status};
      end
      else if (sel == task_file_pkg::SEL_HIGH)
      begin
        if (register_select_lines == task_file_pkg::ADDR_ALT_STATUS)
          rdata_next = {8'h00, ctrl_status};
        else if (register_select_lines == task_file_pkg::ADDR_UNIT_ADDR)
          rdata_next = {8'h00, 1'b0, ctrl_unit_address[6:0]};
      end
    end
  end

  // read data register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rdata_reg <= 16'h0000;
    else
      rdata_reg <= rdata_next;
  end

  logic rd_active, data_word_access, low_drive;
  assign rd_active = !read_strobe_n && !rd_fall;
  assign data_word_access = sel == task_file_pkg::SEL_LOW
    && register_select_lines == task_file_pkg::ADDR_DATA;
  // high-select reads of unmapped codes float
  assign low_drive = rd_active && (sel == task_file_pkg::SEL_LOW
    || (sel == task_file_pkg::SEL_HIGH && register_select_lines[2:1] == 2'b11));

  // data bus drive; first strobe cycle latches, drive starts next cycle
  assign host_data_out = rdata_reg;
  assign host_data_low_oe = low_drive;
  assign host_data_high_oe = rd_active && data_word_access
    && ctrl_word_ready && !ctrl_ecc_phase;

  // indications
  assign host_interrupt_line = irq_reg;
  assign host_interrupt_oe = unit_matches && dig_out_reg[task_file_pkg::BIT_IRQ_GATE];
  assign wide_transfer_indicator_n = 1'b0;
  assign wide_transfer_oe = data_word_access && ctrl_word_ready && !ctrl_ecc_phase;
  assign passed_selftest_line_out_n = 1'b0;
  assign passed_selftest_oe = strap_slave && ctrl_selftest_passed;
  assign slave_seen = !strap_slave && !passed_selftest_line_in_n;
  assign slave_or_activity_line_n = 1'b0;
  assign slave_or_activity_oe = strap_activity_mode ? ctrl_busy : strap_slave_present;

  // controller side
  assign ctrl_write_word = wword_reg;
  assign ctrl_write_word_valid = wword_valid_reg;
  assign ctrl_read_word_taken = rd_rise && data_word_access;
  assign ctrl_command = cmd_reg;
  assign ctrl_command_valid = cmd_valid_reg;
  assign lookahead_enable = lookahead_reg[0];
  assign soft_reset = dig_out_reg[2];

  // checks
  property p_irq_clear;
    @(posedge core_clk) disable iff (rst)
      (wr_rise && sel == task_file_pkg::SEL_LOW
       && register_select_lines == task_file_pkg::ADDR_STATUS
       && !ctrl_irq_req) |=> !irq_reg;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared");
  property p_irq_set;
    @(posedge core_clk) disable iff (rst) ctrl_irq_req |=> irq_reg;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq not set");
  property p_irq_gate;
    @(posedge core_clk) disable iff (rst)
      host_interrupt_oe |-> dig_out_reg[task_file_pkg::BIT_IRQ_GATE] && unit_matches;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq driven ungated");
  property p_no_sel_float;
    @(posedge core_clk) disable iff (rst)
      sel != task_file_pkg::SEL_LOW && sel != task_file_pkg::SEL_HIGH
        |-> !host_data_low_oe && !host_data_high_oe;
  endproperty
  a_no_sel_float: assert property (p_no_sel_float) else $error("bus driven unselected");
  property p_high_only_words;
    @(posedge core_clk) disable iff (rst)
      host_data_high_oe |-> host_data_low_oe && wide_transfer_oe;
  endproperty
  a_high_only_words: assert property (p_high_only_words) else $error("upper byte misuse");
  property p_fault_zero;
    @(posedge core_clk) disable iff (rst) (fault_reg & 8'h29) == 8'h00;
  endproperty
  a_fault_zero: assert property (p_fault_zero) else $error("unused fault bit set");
  property p_unit_fixed;
    @(posedge core_clk) disable iff (rst) unit_head_reg[6:5] == 2'b01;
  endproperty
  a_unit_fixed: assert property (p_unit_fixed) else $error("unit/head fixed bits");
  property p_count_dec;
    @(posedge core_clk) disable iff (rst)
      ctrl_sector_done && ctrl_sector_info.ok |=> count_reg == 8'($past(count_reg) - 8'h01);
  endproperty
  a_count_dec: assert property (p_count_dec) else $error("count not decremented");
  property p_sector_hold;
    @(posedge core_clk) disable iff (rst)
      ctrl_sector_done && !ctrl_sector_info.ok && !wr_rise |=> $stable(sector_reg);
  endproperty
  a_sector_hold: assert property (p_sector_hold) else $error("sector moved on error");
  property p_bad_sel;
    @(posedge core_clk) disable iff (rst)
      sel == task_file_pkg::SEL_BAD && !ctrl_sector_done && !ctrl_fault_load |=> $stable(count_reg)
        && $stable(unit_head_reg) && $stable(dig_out_reg);
  endproperty
  a_bad_sel: assert property (p_bad_sel) else $error("write under dual select");
  // a byte write lands on the strobe's rising edge, one cycle later
  property p_wr_capture;
    @(posedge core_clk) disable iff (rst)
      wr_rise && sel == task_file_pkg::SEL_LOW && !ctrl_sector_done
        && register_select_lines == task_file_pkg::ADDR_COUNT
        |=> count_reg == $past(host_data_in[7:0]);
  endproperty
  a_wr_capture: assert property (p_wr_capture) else $error("write not captured");

endmodule : disk_task_file_host_port
`default_nettype wire

// >>> testbench/host_adapter_model.sv
// host bus adapter model issuing programmed I/O cycles to the drive port
`timescale 1ns/1ps
`default_nettype none

module host_adapter_model (
  // clock
  input wire logic core_clk,
  // address, strobes and write data toward the drive
  output logic low_chip_select_n,
  output logic high_chip_select_n,
  output logic [2:0] register_select_lines,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic address_latch_enable,
  output logic [15:0] host_data_in,
  // answer from the drive
  input wire logic [15:0] host_data_out,
  input wire logic host_data_low_oe,
  input wire logic host_data_high_oe,
  input wire logic wide_transfer_oe
);
  // idle bus: nothing selected, strobes high
  initial
  begin
    {low_chip_select_n, high_chip_select_n, write_strobe_n, read_strobe_n} = 4'hF;
    register_select_lines = 3'h0;
    address_latch_enable = 1'b0;
    host_data_in = 16'h0000;
  end

  // one cycle; strobe low and high phases each span two clocks
  task automatic cyc(input logic [1:0] sel, input logic [2:0] a, input logic w,
    input logic [15:0] d, output logic [15:0] q, output logic [2:0] oe);
    @(negedge core_clk);
    {high_chip_select_n, low_chip_select_n} = sel;
    register_select_lines = a;
    address_latch_enable = ~address_latch_enable; // wiggled so decode cannot lean on it
    host_data_in = w ? d : ~host_data_in; // undriven on reads, never a stale copy
    write_strobe_n = ~w;
    read_strobe_n = w;
    repeat (2) @(negedge core_clk);
    // an undriven lane shows the inverse of the last value, never a stale copy
    q = {host_data_high_oe ? host_data_out[15:8] : ~host_data_out[15:8],
      host_data_low_oe ? host_data_out[7:0] : ~host_data_out[7:0]};
    oe = {wide_transfer_oe, host_data_high_oe, host_data_low_oe};
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    repeat (2) @(negedge core_clk);
    {high_chip_select_n, low_chip_select_n} = 2'b11;
    host_data_in = ~host_data_in;
  endtask : cyc
endmodule : host_adapter_model
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench for the task-file host port
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam logic [1:0] LO = 2'b10; // low select only
  localparam logic [1:0] HI = 2'b01; // high select only
  logic core_clk, rst, low_chip_select_n, high_chip_select_n, write_strobe_n, read_strobe_n;
  logic address_latch_enable, host_data_low_oe, host_data_high_oe, host_interrupt_line;
  logic host_interrupt_oe, wide_transfer_indicator_n, wide_transfer_oe;
  logic passed_selftest_line_out_n, passed_selftest_oe, slave_or_activity_line_n;
  logic slave_or_activity_oe, strap_slave, strap_activity_mode, strap_slave_present;
  logic ctrl_irq_req, ctrl_busy, ctrl_word_ready, ctrl_ecc_phase, ctrl_sector_done;
  logic ctrl_fault_load, ctrl_selftest_passed, ctrl_write_word_valid, ctrl_read_word_taken;
  logic ctrl_command_valid, lookahead_enable, soft_reset, slave_seen, passed_selftest_line_in_n;
  logic [2:0] register_select_lines, oe;
  logic [15:0] host_data_in, host_data_out, ctrl_read_word, ctrl_write_word, q, got_word;
  logic [7:0] ctrl_status, ctrl_fault_value, ctrl_unit_address, ctrl_command, got_cmd;
  task_file_pkg::sector_update_t ctrl_sector_info;
  logic peer_passed_selftest_line_n;
  int num_errors, total_checks, cycles, taken;

  // open-drain passed line; the peer stands for a second drive, high when released
  assign passed_selftest_line_in_n = passed_selftest_oe ? passed_selftest_line_out_n
    : peer_passed_selftest_line_n;

  disk_task_file_host_port disk_task_file_host_port_i (.core_clk, .rst, .low_chip_select_n,
    .high_chip_select_n, .register_select_lines, .write_strobe_n, .read_strobe_n,
    .address_latch_enable, .host_data_in, .host_data_out, .host_data_low_oe,
    .host_data_high_oe, .host_interrupt_line, .host_interrupt_oe, .wide_transfer_indicator_n,
    .wide_transfer_oe, .passed_selftest_line_in_n, .passed_selftest_line_out_n,
    .passed_selftest_oe, .slave_or_activity_line_n, .slave_or_activity_oe, .strap_slave,
    .strap_activity_mode, .strap_slave_present, .ctrl_irq_req, .ctrl_status, .ctrl_busy,
    .ctrl_word_ready, .ctrl_ecc_phase, .ctrl_sector_done, .ctrl_sector_info, .ctrl_fault_load,
    .ctrl_fault_value, .ctrl_selftest_passed, .ctrl_unit_address, .ctrl_read_word,
    .ctrl_write_word, .ctrl_write_word_valid, .ctrl_read_word_taken, .ctrl_command,
    .ctrl_command_valid, .lookahead_enable, .soft_reset, .slave_seen);

  host_adapter_model host_adapter_model_i (.core_clk, .low_chip_select_n, .high_chip_select_n,
    .register_select_lines, .write_strobe_n, .read_strobe_n, .address_latch_enable,
    .host_data_in, .host_data_out, .host_data_low_oe, .host_data_high_oe, .wide_transfer_oe);

  // free-running clock, 40 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // catch one-cycle pulses toward the controller; cut a hang short
  always @(posedge core_clk)
  begin
    cycles++;
    if (ctrl_write_word_valid === 1'b1) got_word = ctrl_write_word;
    if (ctrl_command_valid === 1'b1) got_cmd = ctrl_command;
    if (ctrl_read_word_taken === 1'b1) taken++;
    if (cycles == 20000)
    begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [1:0] s, input logic [2:0] a, input logic [15:0] d);
    host_adapter_model_i.cyc(s, a, 1'b1, d, q, oe);
  endtask : wr

  task automatic rd(input logic [1:0] s, input logic [2:0] a);
    host_adapter_model_i.cyc(s, a, 1'b0, 16'h0000, q, oe);
  endtask : rd

  // byte register read: only the low lane may be driven
  task automatic rdb(input logic [1:0] s, input logic [2:0] a, input logic [7:0] exp);
    rd(s, a);
    chk({8'h00, q[7:0]}, {8'h00, exp});
    chk({13'h0000, oe}, 16'h0001);
  endtask : rdb

  // controller-side one-cycle events
  task automatic ev(input int kind, input task_file_pkg::sector_update_t info);
    @(negedge core_clk);
    ctrl_sector_info = info;
    {ctrl_irq_req, ctrl_sector_done, ctrl_fault_load} = 3'b100 >> kind;
    @(negedge core_clk);
    {ctrl_irq_req, ctrl_sector_done, ctrl_fault_load} = 3'b000;
    @(negedge core_clk);
  endtask : ev

  task automatic t_regs;
    rdb(LO, task_file_pkg::ADDR_COUNT, task_file_pkg::RESET_COUNT);
    rdb(LO, task_file_pkg::ADDR_UNIT_HEAD, task_file_pkg::RESET_UNIT_HEAD);
    wr(LO, task_file_pkg::ADDR_COUNT, 16'hFF55);
    wr(LO, task_file_pkg::ADDR_SECTOR, 16'h0066);
    wr(LO, task_file_pkg::ADDR_TRACK_LO, 16'h00A5);
    wr(LO, task_file_pkg::ADDR_TRACK_HI, 16'h00FF);
    wr(LO, task_file_pkg::ADDR_UNIT_HEAD, 16'h00FF);
    rdb(LO, task_file_pkg::ADDR_COUNT, 8'h55);
    rdb(LO, task_file_pkg::ADDR_SECTOR, 8'h66);
    rdb(LO, task_file_pkg::ADDR_TRACK_LO, 8'hA5);
    rdb(LO, task_file_pkg::ADDR_TRACK_HI, 8'h03);
    rdb(LO, task_file_pkg::ADDR_UNIT_HEAD, 8'hBF);
    wr(LO, task_file_pkg::ADDR_UNIT_HEAD, 16'h0040);
    rdb(LO, task_file_pkg::ADDR_UNIT_HEAD, 8'h20);
    // no select and both selects must neither write nor drive
    for (int s = 0; s < 4; s += 3)
    begin
      wr(s[1:0], task_file_pkg::ADDR_COUNT, 16'h0077);
      rd(s[1:0], task_file_pkg::ADDR_COUNT);
      chk({13'h0000, oe}, 16'h0000);
    end
    rdb(LO, task_file_pkg::ADDR_COUNT, 8'h55);
  endtask : t_regs

  task automatic t_data;
    {ctrl_word_ready, ctrl_read_word} = {1'b1, 16'hBEEF};
    rd(LO, task_file_pkg::ADDR_DATA);
    chk(q, 16'hBEEF);
    chk({13'h0000, oe}, 16'h0007);
    ctrl_ecc_phase = 1'b1;
    rd(LO, task_file_pkg::ADDR_DATA);
    chk({q[7:0], 5'h00, oe}, 16'hEF01);
    chk(16'(taken), 16'h0002);
    wr(LO, task_file_pkg::ADDR_DATA, 16'h5AC3);
    chk(got_word, 16'h00C3);
    ctrl_ecc_phase = 1'b0;
    wr(LO, task_file_pkg::ADDR_DATA, 16'hA5C3);
    chk(got_word, 16'hA5C3);
    ctrl_word_ready = 1'b0;
  endtask : t_data

  task automatic t_fault;
    ctrl_fault_value = 8'hFF;
    ev(2, '0);
    rdb(LO, task_file_pkg::ADDR_FAULT, task_file_pkg::FAULT_USED_MASK);
    ctrl_fault_value = 8'h04;
    ev(2, '0);
    wr(LO, task_file_pkg::ADDR_FAULT, 16'h0001);
    chk({15'h0000, lookahead_enable}, 16'h0001);
    rdb(LO, task_file_pkg::ADDR_FAULT, 8'h04);
  endtask : t_fault

  task automatic t_sector;
    wr(LO, task_file_pkg::ADDR_COUNT, 16'h0000);
    ev(1, {1'b1, 8'h05, 10'h2A5, 4'h7});
    rdb(LO, task_file_pkg::ADDR_COUNT, 8'hFF);
    rdb(LO, task_file_pkg::ADDR_SECTOR, 8'h05);
    rdb(LO, task_file_pkg::ADDR_TRACK_LO, 8'hA5);
    rdb(LO, task_file_pkg::ADDR_TRACK_HI, 8'h02);
    rdb(LO, task_file_pkg::ADDR_UNIT_HEAD, 8'h27);
    ev(1, {1'b0, 8'h09, 10'h2A5, 4'h3});
    rdb(LO, task_file_pkg::ADDR_SECTOR, 8'h05);
    rdb(LO, task_file_pkg::ADDR_UNIT_HEAD, 8'h23);
  endtask : t_sector

  task automatic t_straps;
    {strap_slave, ctrl_selftest_passed} = 2'b11;
    repeat (2) @(negedge core_clk);
    chk({15'h0000, passed_selftest_oe}, 16'h0001);
    strap_slave = 1'b0;
    repeat (2) @(negedge core_clk);
    chk({15'h0000, passed_selftest_oe}, 16'h0000);
    peer_passed_selftest_line_n = 1'b0;
    @(negedge core_clk);
    chk({15'h0000, slave_seen}, 16'h0001);
    peer_passed_selftest_line_n = 1'b1;
    {strap_activity_mode, ctrl_busy} = 2'b11;
    repeat (2) @(negedge core_clk);
    chk({14'h0000, slave_or_activity_oe, slave_or_activity_line_n}, 16'h0002);
    {strap_activity_mode, ctrl_busy, strap_slave_present} = 3'b001;
    repeat (2) @(negedge core_clk);
    chk({15'h0000, slave_or_activity_oe}, 16'h0001);
  endtask : t_straps

  task automatic t_irq;
    wr(LO, task_file_pkg::ADDR_UNIT_HEAD, 16'h0000);
    wr(HI, task_file_pkg::ADDR_ALT_STATUS, 16'h0002);
    ctrl_status = 8'h50;
    ev(0, '0);
    chk({14'h0000, host_interrupt_oe, host_interrupt_line}, 16'h0003);
    rdb(HI, task_file_pkg::ADDR_ALT_STATUS, 8'h50);
    chk({15'h0000, host_interrupt_line}, 16'h0001);
    rdb(LO, task_file_pkg::ADDR_STATUS, 8'h50);
    chk({15'h0000, host_interrupt_line}, 16'h0000);
    ev(0, '0);
    wr(LO, task_file_pkg::ADDR_STATUS, 16'h0020);
    chk({got_cmd, 7'h00, host_interrupt_line}, 16'h2000);
    wr(LO, task_file_pkg::ADDR_UNIT_HEAD, 16'h0010);
    chk({15'h0000, host_interrupt_oe}, 16'h0000);
    wr(LO, task_file_pkg::ADDR_UNIT_HEAD, 16'h0000);
    wr(HI, task_file_pkg::ADDR_ALT_STATUS, 16'h0000);
    chk({15'h0000, host_interrupt_oe}, 16'h0000);
    ctrl_unit_address = 8'hFF;
    rdb(HI, task_file_pkg::ADDR_UNIT_ADDR, 8'h7F);
    for (int a = 0; a < 6; a++)
    begin
      rd(HI, a[2:0]);
      chk({13'h0000, oe}, 16'h0000);
    end
    wr(HI, task_file_pkg::ADDR_ALT_STATUS, 16'h0004);
    chk({15'h0000, soft_reset}, 16'h0001);
    wr(HI, task_file_pkg::ADDR_ALT_STATUS, 16'h0000);
    ctrl_busy = 1'b1;
    rdb(LO, task_file_pkg::ADDR_COUNT, 8'h50);
    ctrl_busy = 1'b0;
  endtask : t_irq

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // reset for ten clocks, then the scenarios in turn
  initial
  begin
    rst = 1'b1;
    {strap_slave, strap_activity_mode, strap_slave_present, ctrl_irq_req} = 4'h0;
    peer_passed_selftest_line_n = 1'b1;
    {ctrl_busy, ctrl_word_ready, ctrl_ecc_phase, ctrl_sector_done} = 4'h0;
    {ctrl_fault_load, ctrl_selftest_passed, ctrl_status, ctrl_fault_value} = 18'h00000;
    {ctrl_unit_address, ctrl_read_word, ctrl_sector_info} = '0;
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    t_regs();
    t_data();
    t_fault();
    t_sector();
    t_straps();
    t_irq();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
